// ---- fbusr_core.sv ----
// Behaviour
// - Four state bits, shown on four parallel outputs, loaded from four parallel inputs.
// - From the first clock edge with clear active, all four stages read low, overriding everything else.
// - Load mode copies all four parallel inputs into the stages on a clock edge.
// - Shift right moves stage 0 toward stage 3; stage 0 takes right serial input.
// - Shift left moves stage 3 toward stage 0; stage 3 takes left serial input.
// - Inhibit mode leaves all four stages unchanged on clock edges.
// - Besides clear, stages change only at a shift clock edge, else keep value.

// ****************************************************************
// Shared constants
// ****************************************************************
package fbusr_pkg;
  localparam int STAGE_COUNT = 4;
  localparam int BUS_ADDR_MIN = 8;

  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT = 2'h2;
  localparam logic [1:0] MODE_LOAD = 2'h3;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PDATA = 8'h04;
  localparam logic [7:0] REG_STEP = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SR_BIT = 2;
  localparam int CTRL_SL_BIT = 3;
  localparam int CTRL_CLR_BIT = 4;
  localparam int CTRL_WIDTH = 5;
  localparam int STEP_BIT = 0;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;
  localparam logic [STAGE_COUNT-1:0] PDATA_RESET = 4'h0;
  localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// ****************************************************************
// Shift register stages
// ****************************************************************
module fbusr_core
  import fbusr_pkg::*;
#(
  parameter int WIDTH = STAGE_COUNT
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clearActive, // Forces all stages low while high
  input wire logic shiftStep, // One-cycle shift clock edge
  input wire logic [1:0] mode, // Operating mode
  input wire logic serialRightIn, // Enters stage 0 on right shift
  input wire logic serialLeftIn, // Enters last stage on left shift
  input wire logic [WIDTH-1:0] parallelIn, // Parallel load data
  output logic [WIDTH-1:0] stageOut // Stage contents
);
  if (WIDTH < 2) begin : g_bad_width
    $error("fbusr_core needs at least two stages");
  end

  logic [WIDTH-1:0] next_stageOut;

  always_comb begin
    next_stageOut = stageOut;
    if (clearActive) begin
      next_stageOut = '0;
    end else if (shiftStep) begin
      unique case (mode)
        MODE_HOLD: next_stageOut = stageOut;
        MODE_RIGHT: next_stageOut = {stageOut[WIDTH-2:0], serialRightIn};
        MODE_LEFT: next_stageOut = {serialLeftIn, stageOut[WIDTH-1:1]};
        MODE_LOAD: next_stageOut = parallelIn;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stageOut <= '0;
    end else begin
      stageOut <= next_stageOut;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_FIRST_LAST_LOAD: assert property (
    shiftStep && !clearActive && mode == 2'h3 |=>
      stageOut[0] == $past(parallelIn[0]) && stageOut[WIDTH-1] == $past(parallelIn[WIDTH-1]))
    else $error("Load did not reach first and last stage");
  AST_CLEAR_LOW: assert property (
    clearActive ##1 clearActive |-> stageOut == '0 ##1 stageOut == '0 || !clearActive)
    else $error("Stages not low under clear");
  AST_CLEAR_WINS: assert property (
    clearActive && shiftStep |=> stageOut == '0)
    else $error("Clear did not override shift edge");
  AST_LOAD: assert property (
    shiftStep && !clearActive && mode == MODE_LOAD |=> stageOut == $past(parallelIn))
    else $error("Parallel load wrong");
  AST_RIGHT: assert property (
    shiftStep && !clearActive && mode == MODE_RIGHT |=>
      stageOut == {$past(stageOut[WIDTH-2:0]), $past(serialRightIn)})
    else $error("Right shift wrong");
  AST_LEFT: assert property (
    shiftStep && !clearActive && mode == MODE_LEFT |=>
      stageOut == {$past(serialLeftIn), $past(stageOut[WIDTH-1:1])})
    else $error("Left shift wrong");
  AST_HOLD: assert property (
    shiftStep && !clearActive && mode == MODE_HOLD |=> $stable(stageOut))
    else $error("Inhibit mode changed stages");
  AST_NO_EDGE: assert property (
    (!shiftStep && !clearActive)[*2] |-> ##1 $stable(stageOut))
    else $error("Stages changed without a shift edge");
  AST_CODE_RIGHT: assert property (
    shiftStep && !clearActive && mode == 2'h1 |=> stageOut[0] == $past(serialRightIn))
    else $error("Code 01 did not shift right");
endmodule

// ---- fbusr_top.sv ----
// ****************************************************************
// Shift register with AXI4-Lite register access
// ****************************************************************
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module fbusr_top
  import fbusr_pkg::*;
#(
  parameter int ADDR_WIDTH = BUS_ADDR_MIN,
  parameter int WIDTH = STAGE_COUNT
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [WIDTH-1:0] stageOut // Stage contents
);
  if (ADDR_WIDTH < BUS_ADDR_MIN || WIDTH != STAGE_COUNT) begin : g_bad_param
    $error("fbusr_top: address too narrow or stage count unsupported");
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] addr);
    logic [7:0] low;
    low = addr[BUS_ADDR_MIN-1:0];
    // A shift rather than a part-select, so the minimum address width still elaborates
    isMapped = ((addr >> BUS_ADDR_MIN) == '0) &&
      (low == REG_CTRL || low == REG_PDATA || low == REG_STEP || low == REG_STATUS);
  endfunction

  // ****************************************************************
  // Write channel state
  // ****************************************************************
  logic awHeld;
  logic [ADDR_WIDTH-1:0] awAddr;
  logic wHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [WIDTH-1:0] pdata;
  logic shiftStep;

  logic next_awHeld;
  logic [ADDR_WIDTH-1:0] next_awAddr;
  logic next_wHeld;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_awready;
  logic next_wready;
  logic [CTRL_WIDTH-1:0] next_ctrl;
  logic [WIDTH-1:0] next_pdata;
  logic next_shiftStep;

  // Address and data are caught in either order; the write lands once both are held
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_pdata = pdata;
    next_shiftStep = 1'b0;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = isMapped(awAddr) ? RESP_OKAY : RESP_DECERR;
      // All fields sit in byte lane 0, so only its strobe matters
      if (isMapped(awAddr) && wStrb[0]) begin
        unique case (awAddr[7:0])
          REG_CTRL: next_ctrl = wData[CTRL_WIDTH-1:0];
          REG_PDATA: next_pdata = wData[WIDTH-1:0];
          REG_STEP: next_shiftStep = wData[STEP_BIT];
          default: next_ctrl = ctrl;
        endcase
      end
    end
    next_awready = !next_awHeld && !next_bvalid;
    next_wready = !next_wHeld && !next_bvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
      wHeld <= 1'b0;
      wData <= DATA_ZERO;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      ctrl <= CTRL_RESET;
      pdata <= PDATA_RESET;
      shiftStep <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      ctrl <= next_ctrl;
      pdata <= next_pdata;
      shiftStep <= next_shiftStep;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic next_rvalid;
  logic next_arready;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Status reads the live stages, so a read right after a step sees the new value
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = DATA_ZERO;
      next_rresp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      if (isMapped(s_axi_araddr)) begin
        unique case (s_axi_araddr[7:0])
          REG_CTRL: next_rdata[CTRL_WIDTH-1:0] = ctrl;
          REG_PDATA: next_rdata[WIDTH-1:0] = pdata;
          REG_STATUS: next_rdata[WIDTH-1:0] = stageOut;
          default: next_rdata = DATA_ZERO;
        endcase
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= DATA_ZERO;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_arready <= next_arready;
    end
  end

  // ****************************************************************
  // Bus and step checks
  // ****************************************************************
  AST_STEP_PULSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    shiftStep |=> !shiftStep)
    else $error("Shift step lasted more than one cycle");
  AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_WIDTH'(REG_STATUS) |=>
      s_axi_rdata[WIDTH-1:0] == $past(stageOut))
    else $error("Status read did not return the stages");
  // A taken response must clear so the next write can be accepted
  AST_BVALID_DROP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response stayed after it was taken");
  AST_READ_ANSWER: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read address taken without an answer");

  // ****************************************************************
  // Shift register
  // ****************************************************************
  fbusr_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clearActive(ctrl[CTRL_CLR_BIT]),
    .shiftStep(shiftStep),
    .mode(ctrl[CTRL_MODE_LSB +: 2]),
    .serialRightIn(ctrl[CTRL_SR_BIT]),
    .serialLeftIn(ctrl[CTRL_SL_BIT]),
    .parallelIn(pdata),
    .stageOut(stageOut)
  );
endmodule

// ---- fbusr_board_model.sv ----
// ****************************************************************
// Board control logic that drives the shift register
// ****************************************************************
module fbusr_board_model
  import fbusr_pkg::*;
(
  input wire logic sys_clk, // Clock
  output logic [7:0] s_axi_awaddr, // AW addr
  output logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  output logic [31:0] s_axi_wdata, // W data
  output logic [3:0] s_axi_wstrb, // W strobes
  output logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B resp
  input wire logic s_axi_bvalid, // B valid
  output logic s_axi_bready, // B ready
  output logic [7:0] s_axi_araddr, // AR addr
  output logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  output logic s_axi_rready // R ready
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Mode and serial bits land through a completed write before any step is issued
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Waits for the answer however long it takes; only the bench watchdog ends a hang
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- fbusr_tb_top.sv ----
// ****************************************************************
// Self-checking bench
// ****************************************************************
module fbusr_tb_top
  import fbusr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, stageOut;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int badCount = 0;
  int nTests = 0;

  always #2.5 sys_clk = ~sys_clk;

  fbusr_top fbusr_top_i (.*);
  fbusr_board_model fbusr_board_model_i (.*);

  function automatic logic [3:0] nextStage(logic [3:0] q, logic [1:0] m, logic sr, logic sl, logic [3:0] pd);
    case (m)
      MODE_RIGHT: return {q[2:0], sr};
      MODE_LEFT: return {sl, q[3:1]};
      MODE_LOAD: return pd;
      default: return q;
    endcase
  endfunction

  task automatic chkStage(input logic [3:0] got, input logic [3:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Register writes land one edge before the stages react
  task automatic wrSettle(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    fbusr_board_model_i.axiWrite(a, d, r);
    @(posedge sys_clk);
    #1;
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r, m;
    logic [3:0] q, pd;
    logic sr, sl, clr;
    void'($urandom(32'h0000_13a6));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    q = STAGE_RESET;
    chkStage(stageOut, q, "reset");
    fbusr_board_model_i.axiRead(REG_CTRL, d, r);
    chkWord(d, 32'h0000_0000, "ctrl reset");
    // Every mode in turn, random serial bits, data and an occasional clear
    for (int i = 0; i < 48; i++) begin
      m = 2'(i);
      {sr, sl, pd} = 6'($urandom);
      clr = ($urandom % 6) == 0;
      wrSettle(REG_PDATA, {28'h0, pd}, r);
      wrSettle(REG_CTRL, {27'h0, clr, sl, sr, m}, r);
      chkWord({30'h0, r}, {30'h0, RESP_OKAY}, "ctrl resp");
      fbusr_board_model_i.axiRead(REG_CTRL, d, r);
      chkWord(d, {27'h0, clr, sl, sr, m}, "ctrl rd");
      fbusr_board_model_i.axiRead(REG_PDATA, d, r);
      chkWord(d, {28'h0, pd}, "pdata rd");
      if (clr) q = STAGE_RESET;
      chkStage(stageOut, q, "no step");
      wrSettle(REG_STEP, 32'h0000_0001, r);
      if (!clr) q = nextStage(q, m, sr, sl, pd);
      chkStage(stageOut, q, "step");
      fbusr_board_model_i.axiRead(REG_STATUS, d, r);
      chkWord(d, {28'h0, q}, "status");
      chkWord({30'h0, r}, {30'h0, RESP_OKAY}, "status resp");
    end
    // Back-to-back right shifts fill every stage from the serial input
    wrSettle(REG_CTRL, {27'h0, 1'b0, 1'b0, 1'b1, MODE_RIGHT}, r);
    repeat (4) wrSettle(REG_STEP, 32'h0000_0001, r);
    chkStage(stageOut, 4'hF, "fill");
    wrSettle(8'h10, 32'h0000_0001, r);
    chkWord({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped wr");
    chkStage(stageOut, 4'hF, "unmapped effect");
    fbusr_board_model_i.axiRead(8'h10, d, r);
    chkWord(d, DATA_ZERO, "unmapped rd");
    chkWord({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped rd resp");
    fbusr_board_model_i.axiRead(REG_STEP, d, r);
    chkWord(d, DATA_ZERO, "step rd");
    summarize();
  end

  initial begin
    #200000;
    badCount++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule
